//--- design/srbh_service_request.sv
// Service-request mask, serial poll status byte, EOI and NRFD hold-off control.
// Assumes the command parser, talker and listener handshake sit outside and
// give one-cycle strobes; device clear and power-up both arrive through nrst
// or devClear.
//
// Functional notes
// - Internal enable mask selects which conditions raise a service request.
// - Mask weights: 1 overflow, 2 full, 4 half, 8 done, 16 ready, 32 error.
// - Several weights summed; every matching mask bit is set.
// - Writing mask zero clears all enables; nothing can request service.
// - Power-up and device clear disable all service-request generation.
// - Status bit 0 set when input is overrange.
// - Bit 1 set on store full, bit 2 on store half full.
// - Bit 3 set when the reading conversion completes.
// - Bit 4 set when all commands are processed and more accepted.
// - Bit 5 set when any of the ten error causes occurs.
// - Bit 6 set when this device has requested service.
// - Bit 7 unused and always reads zero.
// - On a request all status bits latch until the serial poll.
// - Reading the status byte clears bit 6 and drops the request line.
// - Four modes: EOI and hold, hold only, EOI only, neither.
// - Power-up and device clear restore the default mode.
// - With EOI enabled, EOI accompanies the last byte of output.
// - Hold modes finish the execute handshake, then hold NRFD until done.
// - Hold modes also hold off after received EOI and terminator.
// - Function change holds 100, 630 or 160 ms by function.
// - Range change holds 100, 170, or 638 ms per AC range command.
// - Calibration holds 9 s, or 18.5 s on the top resistance ranges.
// - Other commands hold 94 to 110 ms; self-test about 1 s.
// - Reading the error word clears error bit and re-enables requests.
`timescale 1ns/1ps
module srbh_service_request
	import srbh_pkg::*;
#(
	parameter int unsigned HOLD_DC_MS     = HOLD_FUNC_DC_MS,
	parameter int unsigned HOLD_AC_MS     = HOLD_FUNC_AC_MS,
	parameter int unsigned HOLD_DCI_MS    = HOLD_FUNC_DCI_MS,
	parameter int unsigned HOLD_RNG_MS    = HOLD_RANGE_MS,
	parameter int unsigned HOLD_RNGHI_MS  = HOLD_RANGE_HI_MS,
	parameter int unsigned HOLD_RNGAC_MS  = HOLD_RANGE_AC_MS,
	parameter int unsigned HOLD_CALS_MS   = HOLD_CAL_MS,
	parameter int unsigned HOLD_CALHI_MS  = HOLD_CAL_HI_MS,
	parameter int unsigned HOLD_OMIN_MS   = HOLD_OTHER_MIN_MS,
	parameter int unsigned HOLD_OMAX_MS   = HOLD_OTHER_MAX_MS,
	parameter int unsigned HOLD_SELF_MS   = HOLD_SELFTEST_MS,
	parameter int unsigned CYC_MS         = CYC_PER_MS
) (
	input  wire logic              core_clk,
	input  wire logic              nrst,
	input  wire logic              devClear,
	input  wire logic              enableWrite,
	input  wire logic [7:0]        enableValue,
	input  wire logic              modeWrite,
	input  wire logic [1:0]        modeValue,
	input  wire logic              overrangeEvt,
	input  wire logic              storeFullEvt,
	input  wire logic              storeHalfEvt,
	input  wire logic              readingDoneEvt,
	input  wire logic              errorEvt,
	input  wire logic              errorWordQuery,
	input  wire logic              serialPollRead,
	input  wire logic              executeRcvd,
	input  wire logic              eoiRcvd,
	input  wire logic              termRcvd,
	input  wire logic              cmdDone,
	input  wire logic              holdLoad,
	input  wire logic [HCLS_W-1:0] holdClass,
	input  wire logic              talkByteValid,
	input  wire logic              talkLastByte,
	output logic                   srqOut,
	output logic [7:0]             statusByte,
	output logic [7:0]             enableWord,
	output logic [1:0]             endHoldMode,
	output logic                   eoiOut,
	output logic                   nrfdHoldOut,
	output logic                   readyFlag
);

	// ********************************************************************
	// Hold-off period table
	// ********************************************************************
	localparam int unsigned CNT_W = 30;

	// Cycle counts, typical time in milliseconds times cycles per millisecond.
	localparam logic [CNT_W-1:0] CYC_DC    = CNT_W'(HOLD_DC_MS * CYC_MS);
	localparam logic [CNT_W-1:0] CYC_AC    = CNT_W'(HOLD_AC_MS * CYC_MS);
	localparam logic [CNT_W-1:0] CYC_DCI   = CNT_W'(HOLD_DCI_MS * CYC_MS);
	localparam logic [CNT_W-1:0] CYC_RNG   = CNT_W'(HOLD_RNG_MS * CYC_MS);
	localparam logic [CNT_W-1:0] CYC_RNGHI = CNT_W'(HOLD_RNGHI_MS * CYC_MS);
	localparam logic [CNT_W-1:0] CYC_RNGAC = CNT_W'(HOLD_RNGAC_MS * CYC_MS);
	localparam logic [CNT_W-1:0] CYC_CAL   = CNT_W'(HOLD_CALS_MS * CYC_MS);
	localparam logic [CNT_W-1:0] CYC_CALHI = CNT_W'(HOLD_CALHI_MS * CYC_MS);
	localparam logic [CNT_W-1:0] CYC_OMIN  = CNT_W'(HOLD_OMIN_MS * CYC_MS);
	localparam logic [CNT_W-1:0] CYC_OMAX  = CNT_W'(HOLD_OMAX_MS * CYC_MS);
	localparam logic [CNT_W-1:0] CYC_SELF  = CNT_W'(HOLD_SELF_MS * CYC_MS);

	logic [CNT_W-1:0] holdCycles;

	// Each command class picks its typical period; unknown classes use the short one.
	always_comb begin
		unique case (holdClass)
			HC_FUNC_DC:   holdCycles = CYC_DC;
			HC_FUNC_AC:   holdCycles = CYC_AC;
			HC_FUNC_DCI:  holdCycles = CYC_DCI;
			HC_RANGE:     holdCycles = CYC_RNG;
			HC_RANGE_HI:  holdCycles = CYC_RNGHI;
			HC_RANGE_AC:  holdCycles = CYC_RNGAC;
			HC_CAL:       holdCycles = CYC_CAL;
			HC_CAL_HI:    holdCycles = CYC_CALHI;
			HC_OTHER_MIN: holdCycles = CYC_OMIN;
			HC_OTHER_MAX: holdCycles = CYC_OMAX;
			HC_SELFTEST:  holdCycles = CYC_SELF;
			default:      holdCycles = CYC_OMIN;
		endcase
	end

	// ********************************************************************
	// Clear decode and mode
	// ********************************************************************
	wire clrAll = !nrst || devClear;
	wire holdMode = (endHoldMode == EHM_EOI_HOLD) || (endHoldMode == EHM_HOLD_ONLY);
	wire eoiMode  = (endHoldMode == EHM_EOI_HOLD) || (endHoldMode == EHM_EOI_ONLY);

	logic [1:0] mode_q;
	logic [1:0] mode_d;
	logic [5:0] enMask_q;
	logic [5:0] enMask_d;

	// Mode and mask follow their writes; clear wins over a write in the same cycle.
	assign mode_d   = modeWrite ? modeValue : mode_q;
	assign enMask_d = enableWrite ? (enableValue[5:0] & COND_MASK)
	                              : enMask_q;

	always_ff @(posedge core_clk) begin
		if (clrAll) begin
			mode_q   <= EHM_RESET;
			enMask_q <= SRQ_EN_RESET[5:0];
		end else begin
			mode_q   <= mode_d;
			enMask_q <= enMask_d;
		end
	end

	// ********************************************************************
	// Live condition flags
	// ********************************************************************
	logic [5:0] cond_q;
	logic [5:0] condSet;
	logic [5:0] condClr;
	logic [5:0] cond_d;
	logic       errLock_q;
	logic       busyNow;

	// Events are sticky; a set in the same cycle as its clear wins.
	assign condSet[SB_OVERFLOW]   = overrangeEvt;
	assign condSet[SB_STORE_FULL] = storeFullEvt;
	assign condSet[SB_STORE_HALF] = storeHalfEvt;
	assign condSet[SB_DONE]       = readingDoneEvt;
	assign condSet[SB_READY]      = !busyNow;
	assign condSet[SB_ERROR]      = errorEvt;

	// A poll consumes the one-shot events; ready tracks state and error
	// stays until the error word is read.
	assign condClr[SB_OVERFLOW]   = serialPollRead;
	assign condClr[SB_STORE_FULL] = serialPollRead;
	assign condClr[SB_STORE_HALF] = serialPollRead;
	assign condClr[SB_DONE]       = serialPollRead;
	assign condClr[SB_READY]      = busyNow;
	assign condClr[SB_ERROR]      = errorWordQuery;

	assign cond_d = condSet | (cond_q & ~condClr);

	// ********************************************************************
	// Service request and status byte
	// ********************************************************************
	logic       rqs_q;
	logic [5:0] latched_q;
	wire  [5:0] hits     = cond_q & enMask_q;
	// An error request is raised once; further error requests wait for the error word.
	wire  [5:0] hitsGate = {hits[SB_ERROR] & !errLock_q, hits[4:0]};
	wire        raise    = (|hitsGate) && !rqs_q;

	// Request latches the snapshot; a poll releases it; a fresh raise in the
	// poll cycle is deferred one cycle since rqs_q is still high then.
	always_ff @(posedge core_clk) begin
		if (clrAll) begin
			cond_q    <= '0;
			rqs_q     <= 1'b0;
			latched_q <= '0;
			errLock_q <= 1'b0;
		end else begin
			cond_q <= cond_d;
			if (raise) begin
				rqs_q     <= 1'b1;
				latched_q <= cond_q;
			end else if (serialPollRead) begin
				rqs_q <= 1'b0;
			end
			if (raise && hitsGate[SB_ERROR]) begin
				errLock_q <= 1'b1;
			end else if (errorWordQuery) begin
				errLock_q <= 1'b0;
			end
		end
	end

	// Status byte shows the snapshot while a request is pending, else live state.
	wire [5:0] shownBits = rqs_q ? latched_q : cond_q;
	wire [7:0] sb_d      = {1'b0, rqs_q, shownBits};

	// ********************************************************************
	// Hold-off sequencer
	// ********************************************************************
	srbh_hstate_t hs_q;
	srbh_hstate_t hs_d;
	logic         timerBusy;

	// Execute, received EOI or terminator all start a hold in the hold modes.
	wire holdTrig = holdMode && (executeRcvd || eoiRcvd || termRcvd);

	srbh_holdoff_timer #(
		.CNT_W   (CNT_W)
	) uTimer (
		.core_clk (core_clk),
		.nrst     (nrst && !devClear),
		.load     (holdLoad),
		.loadVal  (holdCycles),
		.busy     (timerBusy)
	);

	// The execute byte handshake has already finished when the trigger
	// arrives, so NRFD only stalls the next byte.
	always_comb begin
		hs_d = hs_q;
		unique case (hs_q)
			HS_IDLE: if (holdTrig) hs_d = HS_WAIT;
			// A fresh trigger re-arms the wait, and a load beside cmdDone still times.
			HS_WAIT: if (cmdDone && !holdTrig) hs_d = (timerBusy || holdLoad) ? HS_TIME : HS_IDLE;
			HS_TIME: if (holdTrig) hs_d = HS_WAIT;
				else if (!timerBusy && !holdLoad) hs_d = HS_IDLE;
			default: hs_d = HS_IDLE;
		endcase
	end

	assign busyNow = (hs_q != HS_IDLE);

	// ********************************************************************
	// Output registers
	// ********************************************************************
	// All outputs come straight from flops.
	always_ff @(posedge core_clk) begin
		if (clrAll) begin
			hs_q        <= HS_IDLE;
			srqOut      <= 1'b0;
			statusByte  <= 8'h00;
			enableWord  <= 8'h00;
			endHoldMode <= EHM_RESET;
			eoiOut      <= 1'b0;
			nrfdHoldOut <= 1'b0;
			readyFlag   <= 1'b0;
		end else begin
			hs_q        <= hs_d;
			srqOut      <= rqs_q && !serialPollRead;
			statusByte  <= sb_d;
			enableWord  <= {2'b00, enMask_q};
			endHoldMode <= mode_q;
			eoiOut      <= eoiMode && talkByteValid && talkLastByte;
			nrfdHoldOut <= (hs_d != HS_IDLE);
			readyFlag   <= cond_q[SB_READY];
		end
	end

endmodule

//--- include/srbh_pkg.sv
// Constants and types for the service-request and bus hold-off block.
// Assumes a single 50 MHz core clock; times are kept here in milliseconds and become cycle counts in the service-request block.
package srbh_pkg;

	// ********************************************************************
	// Clock and timing
	// ********************************************************************
	localparam int unsigned CLK_HZ           = 50000000;
	localparam int unsigned CYC_PER_MS       = CLK_HZ / 1000;
	// Hold-off times in milliseconds, as typical figures.
	localparam int unsigned HOLD_FUNC_DC_MS  = 100;
	localparam int unsigned HOLD_FUNC_AC_MS  = 630;
	localparam int unsigned HOLD_FUNC_DCI_MS = 160;
	localparam int unsigned HOLD_RANGE_MS    = 100;
	localparam int unsigned HOLD_RANGE_HI_MS = 170;
	localparam int unsigned HOLD_RANGE_AC_MS = 638;
	localparam int unsigned HOLD_CAL_MS      = 9000;
	localparam int unsigned HOLD_CAL_HI_MS   = 18500;
	localparam int unsigned HOLD_OTHER_MIN_MS = 94;
	localparam int unsigned HOLD_OTHER_MAX_MS = 110;
	localparam int unsigned HOLD_SELFTEST_MS = 1000;

	// ********************************************************************
	// Hold-off command classes
	// ********************************************************************
	localparam int unsigned HCLS_W = 4;
	typedef enum logic [3:0] {
		HC_FUNC_DC    = 4'h0,
		HC_FUNC_AC    = 4'h1,
		HC_FUNC_DCI   = 4'h2,
		HC_RANGE      = 4'h3,
		HC_RANGE_HI   = 4'h4,
		HC_RANGE_AC   = 4'h5,
		HC_CAL        = 4'h6,
		HC_CAL_HI     = 4'h7,
		HC_OTHER_MIN  = 4'h8,
		HC_OTHER_MAX  = 4'h9,
		HC_SELFTEST   = 4'ha
	} srbh_hcls_t;

	// ********************************************************************
	// Status byte and enable word layout
	// ********************************************************************
	localparam int unsigned SB_OVERFLOW  = 0;
	localparam int unsigned SB_STORE_FULL = 1;
	localparam int unsigned SB_STORE_HALF = 2;
	localparam int unsigned SB_DONE      = 3;
	localparam int unsigned SB_READY     = 4;
	localparam int unsigned SB_ERROR     = 5;
	localparam int unsigned SB_RQS       = 6;
	localparam int unsigned NUM_COND     = 6;
	localparam logic [7:0]  SRQ_EN_RESET = 8'h00;
	localparam logic [5:0]  COND_MASK    = 6'h3f;

	// ********************************************************************
	// End / hold-off modes
	// ********************************************************************
	typedef enum logic [1:0] {
		EHM_EOI_HOLD   = 2'h0,
		EHM_HOLD_ONLY  = 2'h1,
		EHM_EOI_ONLY   = 2'h2,
		EHM_NONE       = 2'h3
	} srbh_ehmode_t;
	localparam srbh_ehmode_t EHM_RESET = EHM_EOI_HOLD;

	// Hold-off sequencer states, one-hot.
	typedef enum logic [2:0] {
		HS_IDLE = 3'b001,
		HS_WAIT = 3'b010,
		HS_TIME = 3'b100
	} srbh_hstate_t;

endpackage

//--- design/srbh_holdoff_timer.sv
// Down-counter that times one bus hold-off period.
// Assumes the load value is already a cycle count; counts down on each rising core_clk edge until it reaches zero.
`timescale 1ns/1ps
module srbh_holdoff_timer
	import srbh_pkg::*;
#(
	parameter int unsigned CNT_W = 30
) (
	input  wire logic             core_clk,
	input  wire logic             nrst,
	input  wire logic             load,
	input  wire logic [CNT_W-1:0] loadVal,
	output logic                  busy
);

	// ********************************************************************
	// Counter
	// ********************************************************************
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] cnt_d;

	// A load restarts the period, so back-to-back commands extend the hold.
	assign cnt_d = load ? loadVal : ((cnt_q != '0) ? cnt_q - 1'b1 : cnt_q);
	assign busy  = (cnt_q != '0);

	// Synchronous reset leaves the timer expired.
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end

endmodule

//--- tb/srbh_service_request_properties.sv
// Concurrent checks on the service-request and hold-off block ports.
// Assumes one core_clk domain and an active-low synchronous nrst.
`timescale 1ns/1ps
module srbh_sr_props (
	input wire logic       core_clk,
	input wire logic       nrst,
	input wire logic       devClear,
	input wire logic       enableWrite,
	input wire logic [7:0] enableValue,
	input wire logic       modeWrite,
	input wire logic       serialPollRead,
	input wire logic       executeRcvd,
	input wire logic       eoiRcvd,
	input wire logic       termRcvd,
	input wire logic       talkByteValid,
	input wire logic       talkLastByte,
	input wire logic       srqOut,
	input wire logic [7:0] statusByte,
	input wire logic [7:0] enableWord,
	input wire logic [1:0] endHoldMode,
	input wire logic       eoiOut,
	input wire logic       nrfdHoldOut
);
	// ****************
	// Assertions
	// ****************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);

	property p_mask;
		enableWrite && !devClear ##1 !devClear |=> enableWord == {2'h0, $past(enableValue[5:0], 2)};
	endproperty
	a_mask: assert property (p_mask) else $error("mask readback wrong");
	property p_unused;
		statusByte[7] == 1'b0 && enableWord[7:6] == 2'h0;
	endproperty
	a_unused: assert property (p_unused) else $error("unused bits set");
	property p_clear;
		devClear ##1 !enableWrite && !modeWrite |=> enableWord == 8'h00 && endHoldMode == 2'h0;
	endproperty
	a_clear: assert property (p_clear) else $error("clear left state");
	property p_cause;
		$rose(srqOut) |-> statusByte[6] && (statusByte[5:0] & enableWord[5:0]) != 6'h00;
	endproperty
	a_cause: assert property (p_cause) else $error("request without cause");
	property p_poll;
		serialPollRead && srqOut && !devClear |=> !srqOut;
	endproperty
	a_poll: assert property (p_poll) else $error("poll kept request");
	property p_latch;
		srqOut ##1 srqOut |-> $stable(statusByte[5:0]);
	endproperty
	a_latch: assert property (p_latch) else $error("status moved while pending");
	property p_eoi;
		!devClear |=> eoiOut == ($past(talkByteValid && talkLastByte) && !$past(endHoldMode[0]));
	endproperty
	a_eoi: assert property (p_eoi) else $error("end flag wrong");
	property p_hold;
		(executeRcvd || eoiRcvd || termRcvd) && !endHoldMode[1] && !devClear && !modeWrite
			&& !$past(modeWrite) |=> nrfdHoldOut;
	endproperty
	a_hold: assert property (p_hold) else $error("no hold-off");
	property p_nohold;
		endHoldMode[1] && !nrfdHoldOut && !$past(modeWrite) |=> !nrfdHoldOut;
	endproperty
	a_nohold: assert property (p_nohold) else $error("hold-off in free mode");
endmodule

bind srbh_service_request srbh_sr_props u_props (.core_clk(core_clk), .nrst(nrst),
	.devClear(devClear), .enableWrite(enableWrite), .enableValue(enableValue),
	.modeWrite(modeWrite), .serialPollRead(serialPollRead), .executeRcvd(executeRcvd),
	.eoiRcvd(eoiRcvd), .termRcvd(termRcvd), .talkByteValid(talkByteValid),
	.talkLastByte(talkLastByte), .srqOut(srqOut), .statusByte(statusByte),
	.enableWord(enableWord), .endHoldMode(endHoldMode), .eoiOut(eoiOut),
	.nrfdHoldOut(nrfdHoldOut));

//--- tb/srbh_bus_ctrl_model.sv
// Behavioural bus controller that answers a service request with a serial poll.
// Assumes the device takes a one-cycle poll strobe on core_clk.
`timescale 1ns/1ps
module srbh_bus_ctrl_model (
	input  wire logic       core_clk,
	input  wire logic       srqOut,
	input  wire logic [7:0] statusByte,
	input  wire logic [7:0] pollDelay,
	output logic            serialPollRead,
	output logic [7:0]      polledByte,
	output int              pollCount
);
	// ****************
	// Poll engine
	// ****************
	logic [7:0] waitQ;

	initial begin
		serialPollRead = 1'b0;
		polledByte = 8'h00;
		pollCount = 0;
		waitQ = 8'h00;
	end

	// A programmable delay lets both prompt and slow controllers be tried.
	always @(posedge core_clk) begin
		if (serialPollRead) begin
			serialPollRead <= 1'b0;
			polledByte <= statusByte;
			pollCount <= pollCount + 1;
		end else if (!srqOut) begin
			waitQ <= 8'h00;
		end else if (waitQ == pollDelay) begin
			serialPollRead <= 1'b1;
			waitQ <= 8'h00;
		end else begin
			waitQ <= waitQ + 8'h01;
		end
	end
endmodule

//--- tb/service_request_and_bus_holdoff_tb.sv
// Self-checking bench for the service-request and hold-off block.
// Assumes CYC_MS of 1, so one hold-off millisecond lasts one core_clk cycle.
`timescale 1ns/1ps
module service_request_and_bus_holdoff_tb;
	import srbh_pkg::*;
	logic        core_clk, nrst, enableWrite, modeWrite, talkByteValid, talkLastByte;
	logic [11:0] stb;
	logic [7:0]  enableValue, pollDelay, polledByte, statusByte, enableWord;
	logic [1:0]  modeValue, endHoldMode;
	logic [3:0]  holdClass;
	logic        serialPollRead, srqOut, eoiOut, nrfdHoldOut, readyFlag;
	logic [31:0] seed;
	logic [5:0]  pend, msk, ev;
	int          pollCount, pcStart, failCount, checks, i, m, k, n, e;

	srbh_service_request #(.CYC_MS(1)) u_dut (.core_clk(core_clk), .nrst(nrst),
		.devClear(stb[6]), .enableWrite(enableWrite), .enableValue(enableValue),
		.modeWrite(modeWrite), .modeValue(modeValue), .overrangeEvt(stb[0]),
		.storeFullEvt(stb[1]), .storeHalfEvt(stb[2]), .readingDoneEvt(stb[3]),
		.errorEvt(stb[5]), .errorWordQuery(stb[4]), .serialPollRead(serialPollRead),
		.executeRcvd(stb[7]), .eoiRcvd(stb[8]), .termRcvd(stb[9]), .cmdDone(stb[10]),
		.holdLoad(stb[11]), .holdClass(holdClass), .talkByteValid(talkByteValid),
		.talkLastByte(talkLastByte), .srqOut(srqOut), .statusByte(statusByte),
		.enableWord(enableWord), .endHoldMode(endHoldMode), .eoiOut(eoiOut),
		.nrfdHoldOut(nrfdHoldOut), .readyFlag(readyFlag));
	srbh_bus_ctrl_model u_ctrl (.core_clk(core_clk), .srqOut(srqOut),
		.statusByte(statusByte), .pollDelay(pollDelay), .serialPollRead(serialPollRead),
		.polledByte(polledByte), .pollCount(pollCount));

	// ****************
	// Helpers
	// ****************
	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction

	// Typical hold-off cycles for each command class; unknown classes fall to the shortest.
	function automatic int expHold(input int c);
		case (c)
			0, 3: return 100;
			1: return 630;
			2: return 160;
			4: return 170;
			5: return 638;
			6: return 9000;
			7: return 18500;
			9: return 110;
			10: return 1000;
			default: return 94;
		endcase
	endfunction

	task automatic compare(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			failCount++;
			$display("Error %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic testDone;
		if (failCount == 0 && checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	// One-cycle strobe on any mix of event and command inputs.
	task automatic drv(input logic [11:0] p);
		@(posedge core_clk);
		stb <= p;
		@(posedge core_clk);
		stb <= 12'h000;
	endtask

	task automatic wr(input logic isMode, input logic [7:0] v);
		@(posedge core_clk);
		enableValue <= v;
		modeValue <= v[1:0];
		enableWrite <= !isMode;
		modeWrite <= isMode;
		@(posedge core_clk);
		enableWrite <= 1'b0;
		modeWrite <= 1'b0;
	endtask

	// Waits for request up (0), hold-off released (1) or a finished poll (2).
	task automatic waitFor(input int w, input int lim, output int cnt);
		cnt = 0;
		do begin
			@(negedge core_clk);
			cnt++;
			if (cnt > lim) begin
				failCount++;
				$display("Error %0t: wait limit", $time);
				testDone;
			end
		end while (!((w == 0) ? srqOut === 1'b1 : (w == 1) ? nrfdHoldOut === 1'b0
			: pollCount != pcStart));
	endtask

	// ****************
	// Main sequence
	// ****************
	initial begin
		{nrst, enableWrite, modeWrite, talkByteValid, talkLastByte} = 5'h00;
		{stb, enableValue, modeValue, holdClass, pollDelay} = 34'h0;
		{failCount, checks} = 0;
		seed = 32'h9431;
		repeat (3) @(posedge core_clk);
		nrst <= 1'b1;
		@(negedge core_clk);
		compare({enableWord, endHoldMode, srqOut}, 11'h000);
		for (i = 0; i < 6; i++) begin
			pollDelay <= i[0] ? 8'h14 : 8'h00;
			wr(0, 8'h01 << i);
			pcStart = pollCount;
			if (i != 4) drv(12'h001 << i);
			waitFor(2, 100, n);
			compare(polledByte & 8'hef, (8'h01 << i | 8'h40) & 8'hef);
			wr(0, 8'h00);
			drv(12'h010);
			repeat (30) @(posedge core_clk);
		end
		pend = 6'h00;
		pollDelay <= 8'h14;
		for (i = 0; i < 24; i++) begin
			seed = xs(seed);
			msk = (i == 0) ? 6'h00 : seed[5:0] & 6'h2f;
			ev = (i == 0) ? 6'h2f : seed[13:8] & 6'h2f;
			drv({6'h00, ev});
			pend = pend | ev;
			pcStart = pollCount;
			wr(0, {seed[31:30], msk});
			if ((pend & msk) != 6'h00) begin
				waitFor(0, 10, n);
				drv(12'h001);
				waitFor(2, 60, n);
				compare(polledByte & 8'hef, {2'h1, pend} & 8'hef);
				pend = 6'h00;
			end else begin
				repeat (6) @(negedge core_clk);
				compare(srqOut, 1'b0);
			end
			// Mask off again so the next events cannot raise a request early.
			wr(0, 8'h00);
			drv(12'h010);
			pend[5] = 1'b0;
		end
		wr(0, 8'h01);
		wr(1, 8'h03);
		drv(12'h040);
		@(negedge core_clk);
		compare({enableWord, endHoldMode}, 10'h000);
		drv(12'h001);
		repeat (6) @(negedge core_clk);
		compare(srqOut, 1'b0);
		for (k = 0; k < 12; k++) begin
			e = expHold(k);
			holdClass <= k[3:0];
			drv(12'h080);
			drv(12'h800);
			drv(12'h400);
			waitFor(1, 20000, n);
			compare(n + 2 >= e - 2 && n + 2 <= e + 3, 1'b1);
		end
		holdClass <= 4'h8;
		drv(12'h080);
		drv(12'h800);
		repeat (150) @(negedge core_clk);
		compare(nrfdHoldOut, 1'b1);
		drv(12'h400);
		waitFor(1, 5, n);
		repeat (2) @(negedge core_clk);
		compare(readyFlag, 1'b1);
		for (m = 0; m < 4; m++) begin
			wr(1, 8'(m));
			repeat (3) @(negedge core_clk);
			compare(endHoldMode, m[1:0]);
			@(posedge core_clk);
			talkByteValid <= 1'b1;
			@(posedge core_clk);
			talkLastByte <= 1'b1;
			@(posedge core_clk);
			{talkByteValid, talkLastByte} <= 2'h0;
			@(negedge core_clk);
			compare(eoiOut, !m[0]);
			for (k = 0; k < 3; k++) begin
				drv(12'h080 << k);
				@(negedge core_clk);
				compare(nrfdHoldOut, !m[1]);
				drv(12'h800);
				drv(12'h400);
				waitFor(1, 200, n);
			end
		end
		testDone;
	end
endmodule
